// ---- verilog/uprs_status.sv ----
// Receive status and result registers of the USB function
`timescale 1ns/1ps
module uprs_status #(
  parameter int RUNAWAY_CYCLES = uprs_pkg::RUNAWAY_CYCLES // Watchdog
) (
  input  wire logic       clk,          // 50 MHz clock
  input  wire logic       rst,          // Synchronous reset
  // CPU register access
  input  wire logic [uprs_pkg::ADDR_W-1:0] bus_addr, // Address
  input  wire logic       bus_wr,       // Write strobe
  input  wire logic       bus_rd,       // Read strobe
  input  wire logic [7:0] bus_wdata,    // Write data
  output logic      [7:0] bus_rdata,    // Read data, next cycle
  // Receiver events
  input  wire logic       pid_tok,      // Token PID detected
  input  wire logic       pid_dat,      // Data PID detected
  input  wire logic       pid_hs,       // Handshake PID detected
  input  wire logic       eop_det,      // End of packet
  input  wire logic       se0_det,      // Single-ended zero
  input  wire logic       bus_reset_det, // USB reset signal
  input  wire logic       resume_det,   // Resume level
  // Packet checks, valid at end of packet
  input  wire logic       crc5_err,     // Token CRC failed
  input  wire logic       crc16_err,    // Data CRC failed
  input  wire logic       stuff_err,    // Stuffing violation
  input  wire logic       length_err,   // Abnormal length
  input  wire logic [7:0] rx_pid,       // Received PID
  input  wire logic [7:0] rx_addr,      // Received token address
  input  wire logic       rx_ep1,       // Token for endpoint one
  input  wire logic       rx_ep0,       // Token for endpoint zero
  // Compare values from the compare registers
  input  wire logic [7:0] token_pid_compare_value,     // Token PID
  input  wire logic [7:0] token_address_compare_value, // Address
  input  wire logic [7:0] data_pid_compare_value,      // Data PID
  // USB clock supervision
  input  wire logic       usb_clk_run,  // USB clock running
  output logic            usb_clk_force_off, // Stop USB clock
  // SETUP consequences
  output logic            setup_clear   // Clear reservations, mask
);
  import uprs_pkg::*;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  wire sel_tok = (bus_addr == TOK_RES_ADDR); // Token result
  wire sel_dat = (bus_addr == DAT_RES_ADDR); // Data result
  wire sel_st  = (bus_addr == RX_STAT_ADDR); // Receive status
  wire tok_wr  = bus_wr & sel_tok;           // Token result write
  wire dat_wr  = bus_wr & sel_dat;           // Data result write
  wire st_wr   = bus_wr & sel_st;            // Status write

  // ---------------------------------------------------------------
  // Packet in progress
  // ---------------------------------------------------------------
  logic [2:0] prog_reg;  // Handshake, data, token
  logic [2:0] prog_next; // Next progress bits

  // PID detection sets, end of packet clears; writes ignored
  assign prog_next = eop_det ? 3'h0 :
                     (prog_reg | {pid_hs, pid_dat, pid_tok});

  // Progress bits never see the bus write data
  always_ff @(posedge clk) begin
    if (rst) begin
      prog_reg <= 3'h0;
    end else begin
      prog_reg <= prog_next;
    end
  end

  // ---------------------------------------------------------------
  // Runaway watchdog
  // ---------------------------------------------------------------
  logic run_hit; // Watchdog overrun pulse

  uprs_runaway #(
    .LIMIT     (RUNAWAY_CYCLES)
  ) u_runaway (
    .clk       (clk),
    .rst       (rst),
    .run       (usb_clk_run),
    .expire    (run_hit),
    .force_off (usb_clk_force_off)
  );

  // ---------------------------------------------------------------
  // Bus transition flags
  // ---------------------------------------------------------------
  logic [4:0] ev_set; // Set events, bits 3..7
  logic [4:0] ev_clr; // Software clears
  logic [4:0] ev_q;   // Flag values

  // Reset and resume act alike in idle and suspend
  assign ev_set[0] = eop_det;
  assign ev_set[1] = bus_reset_det;
  assign ev_set[2] = se0_det | bus_reset_det | resume_det;
  assign ev_set[3] = resume_det;
  assign ev_set[4] = run_hit | bus_reset_det | resume_det;

  // Writing zero clears; writing one has no effect
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_flag
      assign ev_clr[gi] = st_wr & ~bus_wdata[ST_EOP + gi];
      uprs_flag u_flag (
        .clk    (clk),
        .rst    (rst),
        .set_in (ev_set[gi]),
        .clr_in (ev_clr[gi]),
        .q      (ev_q[gi])
      );
    end
  endgenerate

  // Whole status byte for read back
  wire [7:0] rx_status = {ev_q, prog_reg};

  // ---------------------------------------------------------------
  // End of packet classification
  // ---------------------------------------------------------------
  // Token result closes on the token's own end of packet
  wire tok_upd = eop_det & prog_reg[ST_TOK];
  // Data result closes on data or handshake end of packet
  wire dat_upd = eop_det & (prog_reg[ST_DAT] | prog_reg[ST_HS]);

  // ---------------------------------------------------------------
  // Token result
  // ---------------------------------------------------------------
  wire adr_match = (rx_addr[6:0] ==
                    token_address_compare_value[6:0]);
  wire tpid_match = (rx_pid == token_pid_compare_value);
  wire setup_hit  = (rx_pid == SETUP_PID);

  logic [7:0] tok_reg;  // Token result register
  logic [7:0] tok_next; // Next token result
  logic [7:0] tok_new;  // Freshly captured result

  // Captured fields of a finished token
  assign tok_new[RS_CRC] = crc5_err;
  assign tok_new[RS_STF] = stuff_err;
  assign tok_new[RS_LEN] = length_err;
  assign tok_new[RS_EP1] = rx_ep1;
  assign tok_new[RS_EP0] = rx_ep0;
  assign tok_new[RS_ADR] = adr_match;
  assign tok_new[RS_PID] = tpid_match;
  assign tok_new[RS_SET] = setup_hit;

  // Hardware capture wins over a software write
  assign tok_next = tok_upd ? tok_new :
                    tok_wr  ? bus_wdata : tok_reg;

  // Token result storage
  always_ff @(posedge clk) begin
    if (rst) begin
      tok_reg <= REG_RESET;
    end else begin
      tok_reg <= tok_next;
    end
  end

  // ---------------------------------------------------------------
  // SETUP clearing pulse
  // ---------------------------------------------------------------
  logic setup_reg;  // Clear pulse
  logic setup_next; // Next pulse

  // Fires when the SETUP flag goes from zero to one
  assign setup_next = tok_upd & setup_hit & ~tok_reg[RS_SET];
  assign setup_clear = setup_reg;

  // One-cycle pulse, aligned with the flag rising
  always_ff @(posedge clk) begin
    if (rst) begin
      setup_reg <= 1'b0;
    end else begin
      setup_reg <= setup_next;
    end
  end

  // ---------------------------------------------------------------
  // Data and handshake result
  // ---------------------------------------------------------------
  wire dpid_match = (rx_pid == data_pid_compare_value);
  // Handshakes carry no CRC, so only data packets can fail it
  wire dcrc_bad   = crc16_err & prog_reg[ST_DAT];

  logic [7:0] dat_reg;  // Data result register
  logic [7:0] dat_next; // Next data result
  logic [7:0] dat_new;  // Freshly captured result

  // Captured fields; unused bits stay zero
  assign dat_new = {dcrc_bad,
                    stuff_err,
                    length_err,
                    3'h0,
                    dpid_match,
                    1'b0};

  // Hardware capture wins over a software write
  assign dat_next = dat_upd ? dat_new :
                    dat_wr  ? (bus_wdata & DAT_RES_MASK) : dat_reg;

  // Data result storage
  always_ff @(posedge clk) begin
    if (rst) begin
      dat_reg <= REG_RESET;
    end else begin
      dat_reg <= dat_next;
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  logic [7:0] rd_next; // Selected register
  logic [7:0] rd_reg;  // Registered read data

  // Unmapped addresses read as zero
  assign rd_next = !bus_rd ? rd_reg :
                   sel_tok ? tok_reg :
                   sel_dat ? dat_reg :
                   sel_st  ? rx_status : 8'h00;
  assign bus_rdata = rd_reg;

  // Read data holds until the next read
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_reg <= 8'h00;
    end else begin
      rd_reg <= rd_next;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // End of packet latches its flag
  a_eop_flag_set: assert property (
    eop_det |=> rx_status[ST_EOP])
    else $error("eop flag not set");

  // Bus reset leaves reset, SE0 and runaway set
  a_bus_reset_flags: assert property (
    bus_reset_det |=> rx_status[ST_BRST] && rx_status[ST_SE0]
                      && rx_status[ST_RUN])
    else $error("bus reset flags wrong");

  // Resume leaves resume, SE0 and runaway set
  a_resume_flags: assert property (
    resume_det |=> rx_status[ST_RSM] && rx_status[ST_SE0]
                   && rx_status[ST_RUN])
    else $error("resume flags wrong");

  // SE0 latches its flag
  a_se0_flag_set: assert property (
    se0_det |=> rx_status[ST_SE0])
    else $error("se0 flag not set");

  // An event beats a same-cycle software clear
  a_set_beats_clear: assert property (
    se0_det && st_wr && !bus_wdata[ST_SE0] |=> rx_status[ST_SE0])
    else $error("clear beat the event");

  // Software cannot raise the eop flag
  a_sw_no_set: assert property (
    st_wr && !eop_det && !rx_status[ST_EOP]
      |=> !rx_status[ST_EOP])
    else $error("software set eop flag");

  // Writing zero clears the eop flag
  a_sw_clear: assert property (
    st_wr && !bus_wdata[ST_EOP] && !eop_det |=> !rx_status[ST_EOP])
    else $error("eop flag not cleared");

  // Progress bits ignore writes when no packet event
  a_prog_read_only: assert property (
    st_wr && !eop_det && !pid_tok && !pid_dat && !pid_hs
      |=> $stable(rx_status[2:0]))
    else $error("progress bits written");

  // Token PID opens the token progress bit
  a_tok_progress: assert property (
    pid_tok && !eop_det |=> rx_status[ST_TOK])
    else $error("token progress lost");

  // End of packet closes every progress bit
  a_eop_clears_prog: assert property (
    eop_det |=> rx_status[2:0] == 3'h0)
    else $error("progress bit stuck");

  // Address match captured at token end, bits 6..0 only
  a_tok_addr_match: assert property (
    tok_upd |=> tok_reg[RS_ADR] == ($past(rx_addr[6:0]) ==
                $past(token_address_compare_value[6:0])))
    else $error("address match wrong");

  // Token PID match captured at token end
  a_tok_pid_match: assert property (
    tok_upd |=> tok_reg[RS_PID] ==
                ($past(rx_pid) == $past(token_pid_compare_value)))
    else $error("token pid match wrong");

  // Token result only moves at its end of packet or a write
  a_tok_hold: assert property (
    !tok_upd && !tok_wr |=> $stable(tok_reg))
    else $error("token result changed");

  // Data result only moves at its end of packet or a write
  a_dat_hold: assert property (
    !dat_upd && !dat_wr |=> $stable(dat_reg))
    else $error("data result changed");

  // CRC16 failure counts only for data packets
  a_dat_crc_flag: assert property (
    dat_upd |=> dat_reg[RS_CRC] ==
                ($past(crc16_err) && $past(rx_status[ST_DAT])))
    else $error("data crc flag wrong");

  // Watchdog overrun raises the flag and stops the clock
  a_runaway_stop: assert property (
    run_hit |=> rx_status[ST_RUN] && usb_clk_force_off)
    else $error("runaway not handled");

  // Forced stop holds while the USB clock is still requested
  a_force_hold: assert property (
    usb_clk_force_off && usb_clk_run |=> usb_clk_force_off)
    else $error("forced stop dropped");

  // Clearing pulse comes only with the SETUP flag rising
  a_setup_pulse: assert property (
    setup_clear |-> tok_reg[RS_SET] && !$past(tok_reg[RS_SET]))
    else $error("setup clear misplaced");

  // A SETUP token closing with the flag low fires the pulse
  a_setup_rise: assert property (
    tok_upd && rx_pid == SETUP_PID && !tok_reg[RS_SET] |=> setup_clear)
    else $error("setup clear missing");

  // Reset leaves every register and output at zero
  a_reset_zero: assert property (disable iff (1'b0)
    rst |=> tok_reg == 8'h00 && dat_reg == 8'h00
            && rx_status == 8'h00
            && !setup_clear && !usb_clk_force_off)
    else $error("registers not cleared");

  // Main scenarios reached
  c_setup_seen: cover property (setup_clear);
  c_data_crc_bad: cover property (dat_upd && dcrc_bad);
  c_runaway: cover property (run_hit);
  c_bus_reset: cover property (bus_reset_det);
  c_token_match: cover property (tok_upd && adr_match && tpid_match);
endmodule

// ---- inc/uprs_pkg.sv ----
// Constants of the USB packet receive status block
package uprs_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int          ADDR_W        = 16;     // Bus address width
  localparam logic [15:0] TOK_RES_ADDR  = 16'hff62; // Token result
  localparam logic [15:0] DAT_RES_ADDR  = 16'hff65; // Data result
  localparam logic [15:0] RX_STAT_ADDR  = 16'hff67; // Receive status
  localparam logic [7:0]  REG_RESET     = 8'h00;  // All registers
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int ST_TOK   = 0; // Token in progress
  localparam int ST_DAT   = 1; // Data in progress
  localparam int ST_HS    = 2; // Handshake in progress
  localparam int ST_EOP   = 3; // End of packet seen
  localparam int ST_BRST  = 4; // Bus reset seen
  localparam int ST_SE0   = 5; // Single-ended zero seen
  localparam int ST_RSM   = 6; // Resume received
  localparam int ST_RUN   = 7; // USB timer runaway
  localparam int RS_CRC   = 7; // CRC error
  localparam int RS_STF   = 6; // Stuffing error
  localparam int RS_LEN   = 5; // Length error
  localparam int RS_EP1   = 4; // Endpoint one token
  localparam int RS_EP0   = 3; // Endpoint zero token
  localparam int RS_ADR   = 2; // Token address match
  localparam int RS_PID   = 1; // PID match
  localparam int RS_SET   = 0; // SETUP token
  localparam logic [7:0] DAT_RES_MASK = 8'he2; // Implemented data bits
  localparam logic [7:0] SETUP_PID    = 8'h2d; // SETUP token PID
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_KHZ        = 50000;  // Block clock rate
  localparam int RUNAWAY_NS     = 85300;  // 85.3 us USB clock limit
  // Product exceeds the signed 32-bit int range, so work it out in 64 bits
  localparam int RUNAWAY_CYCLES =
    int'((longint'(RUNAWAY_NS) * CLK_KHZ) / 64'd1000000);
endpackage

// ---- verilog/uprs_flag.sv ----
// Sticky event flag, set wins over clear
`timescale 1ns/1ps
module uprs_flag (
  input  wire logic clk,    // Block clock
  input  wire logic rst,    // Synchronous reset
  input  wire logic set_in, // Hardware event
  input  wire logic clr_in, // Software clear
  output logic      q       // Flag value
);
  // ---------------------------------------------------------------
  // Flag register
  // ---------------------------------------------------------------
  logic q_reg;  // Stored flag
  logic q_next; // Next flag

  // Event beats a same-cycle clear
  assign q_next = set_in | (q_reg & ~clr_in);
  assign q      = q_reg;

  // Hold the flag
  always_ff @(posedge clk) begin
    if (rst) begin
      q_reg <= 1'b0;
    end else begin
      q_reg <= q_next;
    end
  end
endmodule

// ---- verilog/uprs_runaway.sv ----
// USB clock runaway watchdog
`timescale 1ns/1ps
module uprs_runaway #(
  parameter int LIMIT = 4265 // Cycles before USB clock is forced off
) (
  input  wire logic clk,       // Block clock
  input  wire logic rst,       // Synchronous reset
  input  wire logic run,       // USB clock running
  output logic      expire,    // One-cycle overrun pulse
  output logic      force_off  // Hold USB clock stopped
);
  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  localparam int CW = $clog2(LIMIT + 1); // Counter width
  logic [CW-1:0] cnt_reg;   // Running time
  logic [CW-1:0] cnt_next;  // Next count
  logic          off_reg;   // Forced off
  logic          off_next;  // Next forced off
  logic          hit;       // Limit reached

  // Limit reached while clock still runs
  assign hit      = run & ~off_reg & (cnt_reg == CW'(LIMIT - 1));
  // Count only while running; restart whenever clock stops
  assign cnt_next = (!run || off_reg) ? '0 : cnt_reg + CW'(1);
  // Stay off until the USB clock request drops
  assign off_next = hit | (off_reg & run);
  assign expire   = hit;
  assign force_off = off_reg;

  // Counter and stop state
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= '0;
      off_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      off_reg <= off_next;
    end
  end
endmodule

// ---- tb/uprs_host_model.sv ----
// Behavioural USB host driving the receiver event inputs
`timescale 1ns/1ps
module uprs_host_model (
  input  wire logic  clk,           // Block clock
  output logic       pid_tok,       // Token PID pulse
  output logic       pid_dat,       // Data PID pulse
  output logic       pid_hs,        // Handshake PID pulse
  output logic       eop_det,       // End of packet pulse
  output logic       se0_det,       // SE0 pulse
  output logic       bus_reset_det, // Bus reset pulse
  output logic       resume_det,    // Resume pulse
  output logic       crc5_err,      // Token CRC failed
  output logic       crc16_err,     // Data CRC failed
  output logic       stuff_err,     // Stuffing violation
  output logic       length_err,    // Abnormal length
  output logic [7:0] rx_pid,        // Received PID
  output logic [7:0] rx_addr,       // Received address
  output logic       rx_ep1,        // Endpoint one
  output logic       rx_ep0         // Endpoint zero
);
  // ---------------------------------------------------------------
  // Idle bus at time zero
  // ---------------------------------------------------------------
  initial begin
    {pid_tok, pid_dat, pid_hs, eop_det} = 4'h0;
    {se0_det, bus_reset_det, resume_det} = 3'h0;
    {crc5_err, crc16_err, stuff_err, length_err, rx_ep1, rx_ep0} = 6'h00;
    rx_pid = 8'h00;
    rx_addr = 8'h00;
  end
  // Move just after the next rising edge
  task automatic step();
    @(posedge clk) #1;
  endtask
  // ---------------------------------------------------------------
  // Packet phases
  // ---------------------------------------------------------------
  // PID first, one cycle
  task automatic open_pkt(input int kind);
    {pid_hs, pid_dat, pid_tok} = 3'b001 << kind;
    step();
    {pid_hs, pid_dat, pid_tok} = 3'b000;
  endtask
  // End of packet with the check results of that packet
  task automatic close_pkt(input logic [7:0] pid, input logic [7:0] adr,
                           input logic [5:0] flg);
    {crc5_err, crc16_err, stuff_err, length_err, rx_ep1, rx_ep0} = flg;
    rx_pid = pid;
    rx_addr = adr;
    eop_det = 1'b1;
    step();
    eop_det = 1'b0;
    // Released lines do not keep their last value
    {crc5_err, crc16_err, stuff_err, length_err, rx_ep1, rx_ep0} = ~flg;
    rx_pid = ~pid;
    rx_addr = ~adr;
  endtask
  // Bus condition pulse: 0 SE0, 1 bus reset, 2 resume
  task automatic bus_event(input int which);
    {resume_det, bus_reset_det, se0_det} = 3'b001 << which;
    step();
    {resume_det, bus_reset_det, se0_det} = 3'b000;
  endtask
endmodule

// ---- tb/usb_packet_receive_status_bench.sv ----
// Self-checking bench for the packet receive status block
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  num_errors++; $display("unexpected at %0t: got %h want %h", \
  $time, (g), (e)); end end
module usb_packet_receive_status_bench;
  import uprs_pkg::*;
  localparam int RUN_LIM = 16; // Shortened watchdog
  logic        clk, rst, bus_wr, bus_rd, usb_clk_run;
  logic [15:0] bus_addr;
  logic [7:0]  bus_wdata, bus_rdata, tok_cmp, adr_cmp, dat_cmp;
  logic        pid_tok, pid_dat, pid_hs, eop_det, se0_det, brst, rsm;
  logic        crc5, crc16, stf, len, ep1, ep0, force_off, setup_clear;
  logic [7:0]  rx_pid, rx_addr, m_stat, m_tok, m_dat, pid, adr;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          n, k;
  uprs_status #(.RUNAWAY_CYCLES(RUN_LIM)) u_dut (
    .clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .pid_tok(pid_tok), .pid_dat(pid_dat), .pid_hs(pid_hs),
    .eop_det(eop_det), .se0_det(se0_det), .bus_reset_det(brst),
    .resume_det(rsm), .crc5_err(crc5), .crc16_err(crc16),
    .stuff_err(stf), .length_err(len), .rx_pid(rx_pid),
    .rx_addr(rx_addr), .rx_ep1(ep1), .rx_ep0(ep0),
    .token_pid_compare_value(tok_cmp),
    .token_address_compare_value(adr_cmp),
    .data_pid_compare_value(dat_cmp), .usb_clk_run(usb_clk_run),
    .usb_clk_force_off(force_off), .setup_clear(setup_clear));
  uprs_host_model u_host (
    .clk(clk), .pid_tok(pid_tok), .pid_dat(pid_dat), .pid_hs(pid_hs),
    .eop_det(eop_det), .se0_det(se0_det), .bus_reset_det(brst),
    .resume_det(rsm), .crc5_err(crc5), .crc16_err(crc16),
    .stuff_err(stf), .length_err(len), .rx_pid(rx_pid),
    .rx_addr(rx_addr), .rx_ep1(ep1), .rx_ep0(ep0));
  // ---------------------------------------------------------------
  // Clock and bus tasks
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic step();
    @(posedge clk) #1;
  endtask
  // One-cycle write strobe, then a gap
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus_wr = 1'b1;
    bus_addr = a;
    bus_wdata = d;
    step();
    bus_wr = 1'b0;
    step();
  endtask
  // Read, data one cycle after the strobe edge
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    bus_rd = 1'b1;
    bus_addr = a;
    step();
    bus_rd = 1'b0;
    `CHK(bus_rdata, e)
    step();
  endtask
  // All three registers against the model
  task automatic chk_all();
    rd_chk(RX_STAT_ADDR, m_stat);
    rd_chk(TOK_RES_ADDR, m_tok);
    rd_chk(DAT_RES_ADDR, m_dat);
  endtask
  // Whole packet with model update: 0 token, 1 data, 2 handshake
  task automatic pkt(input int kind, input logic [7:0] p,
                     input logic [7:0] a, input logic [5:0] f);
    logic [7:0] r;
    logic       set_exp;
    u_host.open_pkt(kind);
    rd_chk(RX_STAT_ADDR, m_stat | (8'h01 << kind));
    u_host.close_pkt(p, a, f);
    m_stat[ST_EOP] = 1'b1;
    set_exp = 1'b0;
    if (kind == 0) begin
      r = {f[5], f[3:0], a[6:0] == adr_cmp[6:0], p == tok_cmp,
           p == SETUP_PID};
      set_exp = r[0] & ~m_tok[0];
      m_tok = r;
    end else begin
      m_dat = {f[4] & (kind == 1), f[3:2], 3'b000, p == dat_cmp, 1'b0};
    end
    `CHK(setup_clear, set_exp)
    rd_chk(RX_STAT_ADDR, m_stat);
    rd_chk(TOK_RES_ADDR, m_tok);
    rd_chk(DAT_RES_ADDR, m_dat);
  endtask
  // Closing report
  task automatic wrap_up();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {rst, bus_wr, bus_rd, usb_clk_run} = 4'b1000;
    bus_addr = 16'h0000;
    bus_wdata = 8'h00;
    {tok_cmp, adr_cmp, dat_cmp} = 24'h000000;
    {m_stat, m_tok, m_dat} = 24'h000000;
    void'($urandom(32'h4b666aad));
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    chk_all();
    // Bus conditions, flags sticky, writes of one ignored
    for (k = 0; k < 3; k++) begin
      u_host.bus_event(k);
      m_stat = (k == 0) ? 8'h20 : (k == 1) ? 8'hb0 : 8'he0;
      rd_chk(RX_STAT_ADDR, m_stat);
      wr(RX_STAT_ADDR, 8'hff);
      rd_chk(RX_STAT_ADDR, m_stat);
      wr(RX_STAT_ADDR, 8'h00);
      m_stat = 8'h00;
      rd_chk(RX_STAT_ADDR, m_stat);
    end
    // Event and software clear in one cycle: the event wins
    fork
      u_host.bus_event(0);
      wr(RX_STAT_ADDR, 8'h00);
    join
    rd_chk(RX_STAT_ADDR, 8'h20);
    wr(RX_STAT_ADDR, 8'h00);
    rd_chk(RX_STAT_ADDR, m_stat);
    // Result registers writable, unmapped places inert
    wr(TOK_RES_ADDR, 8'ha5);
    wr(DAT_RES_ADDR, 8'hff);
    wr(16'hff63, 8'hff);
    m_tok = 8'ha5;
    m_dat = DAT_RES_MASK;
    chk_all();
    rd_chk(16'hff60, 8'h00);
    // Interrupted runs restart the watchdog
    for (k = 0; k < 2; k++) begin
      usb_clk_run = 1'b1;
      repeat (RUN_LIM - 6) step();
      usb_clk_run = 1'b0;
      step();
    end
    `CHK(force_off, 1'b0)
    // Long run forces the USB clock off
    usb_clk_run = 1'b1;
    for (n = 0; n < 40 && force_off !== 1'b1; n++) step();
    `CHK(n >= RUN_LIM && n <= RUN_LIM + 2, 1'b1)
    if (n == 40) wrap_up();
    m_stat[ST_RUN] = 1'b1;
    rd_chk(RX_STAT_ADDR, m_stat);
    usb_clk_run = 1'b0;
    step();
    step();
    `CHK(force_off, 1'b0)
    // Random packets with matching and mismatching compares
    for (int i = 0; i < 80; i++) begin
      k = $urandom_range(2);
      pid = ($urandom_range(3) == 0) ? SETUP_PID : 8'($urandom);
      adr = 8'($urandom);
      adr_cmp = $urandom_range(1) ? adr ^ 8'h80 : 8'($urandom);
      tok_cmp = $urandom_range(1) ? pid : 8'($urandom);
      dat_cmp = $urandom_range(1) ? pid : 8'($urandom);
      if ($urandom_range(3) == 0) begin
        wr(TOK_RES_ADDR, 8'h00);
        m_tok = 8'h00;
      end
      pkt(k, pid, adr, 6'($urandom));
    end
    // Second reset in mid-run
    rst = 1'b1;
    step();
    step();
    rst = 1'b0;
    {m_stat, m_tok, m_dat} = 24'h000000;
    chk_all();
    wrap_up();
  end
endmodule
